// ### hw/asac_ctrl.v
// automatic sound triggers and analog mode control for a sound decoder
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "asac_defines.vh"
// Summary of operation
// - separate auto sound enables for analog, digital
// - five independent enable bits, weights 16..1
// - stop one toot; start two fwd, three rev
// - upward spike plays long long short long
// - short steam release on every stop but an overvoltage shutdown
// - bell on at on point, off outside
// - off point not above on: never on
// - after off, re-on only at on point
// - rise by sensitivity triggers crossing whistle
// - drop by sensitivity triggers brake squeal
// - analog needs alt mode 1 and cfg bit
// - analog: reverse when stopped, no comp, auto chuff
// - analog over 21 V: shutdown, flash code 10
// - error code flashed as count of blinks
// - entering analog forces F1-F8 from byte one
// - byte two forces F0f F0r F9-F12
// - forced inputs act like key presses
// - start threshold 7.5 V plus offset tenths
// - analog average motor voltage limited, not peak
// - transponder compat 1 on, 0 off default
// - transponder setting applies after power cycle
module asac_ctrl #(
	parameter [27:0] SAMPLE_CYC = `ASAC_SAMPLE_CYC,
	parameter [27:0] FLASH_CYC = `ASAC_FLASH_CYC,
	parameter [27:0] GAP_CYC = `ASAC_GAP_CYC
) (
	// clock and reset
	input wire mclk,
	input wire reset,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// power and track sensing
	input wire track_dc,
	input wire power_cycle,
	input wire [8:0] track_dv,
	// command side
	input wire [6:0] cmd_step,
	input wire cmd_dir_fwd,
	// motor and exhaust control
	output reg [6:0] speed_step_q,
	output reg dir_fwd_q,
	output reg [8:0] start_dv_q,
	output reg [7:0] max_avg_dv_q,
	output reg load_comp_en_q,
	output reg auto_exhaust_q,
	output reg [7:0] chuff_rate_q,
	output reg shutdown_q,
	// function inputs forced on
	output reg [13:0] func_force_q,
	// sound triggers
	output reg toot_go_q,
	output reg [1:0] toot_count_q,
	output reg [1:0] toot_len_q,
	output reg crossing_go_q,
	output reg steam_go_q,
	output reg squeal_go_q,
	output reg bell_on_q,
	// status
	output reg analog_q,
	output reg xpond_compat_q,
	output reg fault_lamp_q,
	output reg head_flash_q,
	output reg back_flash_q
);
	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	reg [7:0] alt_power_q;
	reg [7:0] force_lo_q;
	reg [7:0] force_hi_q;
	reg [7:0] basic_cfg_q;
	reg [7:0] xpond_q;
	reg [7:0] start_v_q;
	reg [7:0] max_v_q;
	reg [7:0] chuff_q;
	reg [7:0] bell_on_sp_q;
	reg [7:0] bell_off_sp_q;
	reg [7:0] xing_sens_q;
	reg [7:0] squeal_sens_q;
	reg [7:0] en_analog_q;
	reg [7:0] en_digital_q;
	reg [7:0] rdata_d;
	always @(posedge mclk) begin
		if (reset) begin
			alt_power_q <= `ASAC_RST_ALT_POWER;
			force_lo_q <= `ASAC_RST_FORCE_LO;
			force_hi_q <= `ASAC_RST_FORCE_HI;
			basic_cfg_q <= `ASAC_RST_BASIC_CFG;
			xpond_q <= `ASAC_RST_XPOND;
			start_v_q <= `ASAC_RST_START_V;
			max_v_q <= `ASAC_RST_MAX_V;
			chuff_q <= `ASAC_RST_CHUFF;
			bell_on_sp_q <= `ASAC_RST_BELL_ON;
			bell_off_sp_q <= `ASAC_RST_BELL_OFF;
			xing_sens_q <= `ASAC_RST_XING_SENS;
			squeal_sens_q <= `ASAC_RST_SQUEAL_SENS;
			en_analog_q <= `ASAC_RST_EN_ANALOG;
			en_digital_q <= `ASAC_RST_EN_DIGITAL;
		end else if (reg_wr) begin
			case (reg_addr)
				`ASAC_OFS_ALT_POWER: alt_power_q <= reg_wdata;
				`ASAC_OFS_FORCE_LO: force_lo_q <= reg_wdata;
				`ASAC_OFS_FORCE_HI: force_hi_q <= reg_wdata;
				`ASAC_OFS_BASIC_CFG: basic_cfg_q <= reg_wdata;
				`ASAC_OFS_XPOND: xpond_q <= reg_wdata;
				`ASAC_OFS_START_V: start_v_q <= reg_wdata;
				`ASAC_OFS_MAX_V: max_v_q <= reg_wdata;
				`ASAC_OFS_CHUFF: chuff_q <= reg_wdata;
				`ASAC_OFS_BELL_ON: bell_on_sp_q <= reg_wdata;
				`ASAC_OFS_BELL_OFF: bell_off_sp_q <= reg_wdata;
				`ASAC_OFS_XING_SENS: xing_sens_q <= reg_wdata;
				`ASAC_OFS_SQUEAL_SENS: squeal_sens_q <= reg_wdata;
				`ASAC_OFS_EN_ANALOG: en_analog_q <= reg_wdata;
				`ASAC_OFS_EN_DIGITAL: en_digital_q <= reg_wdata;
				default: ;
			endcase
		end
	end
	// ----------------------------------------
	// read port, data in the cycle after the strobe
	// ----------------------------------------
	always @* begin
		case (reg_addr)
			`ASAC_OFS_ALT_POWER: rdata_d = alt_power_q;
			`ASAC_OFS_FORCE_LO: rdata_d = force_lo_q;
			`ASAC_OFS_FORCE_HI: rdata_d = force_hi_q;
			`ASAC_OFS_BASIC_CFG: rdata_d = basic_cfg_q;
			`ASAC_OFS_XPOND: rdata_d = xpond_q;
			`ASAC_OFS_START_V: rdata_d = start_v_q;
			`ASAC_OFS_MAX_V: rdata_d = max_v_q;
			`ASAC_OFS_CHUFF: rdata_d = chuff_q;
			`ASAC_OFS_BELL_ON: rdata_d = bell_on_sp_q;
			`ASAC_OFS_BELL_OFF: rdata_d = bell_off_sp_q;
			`ASAC_OFS_XING_SENS: rdata_d = xing_sens_q;
			`ASAC_OFS_SQUEAL_SENS: rdata_d = squeal_sens_q;
			`ASAC_OFS_EN_ANALOG: rdata_d = en_analog_q;
			`ASAC_OFS_EN_DIGITAL: rdata_d = en_digital_q;
			`ASAC_OFS_STATUS: rdata_d = {2'b00, xpond_compat_q, bell_on_q, shutdown_q,
				dir_fwd_q, speed_step_q != 7'h00, analog_q};
			default: rdata_d = 8'h00;
		endcase
	end
	always @(posedge mclk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
	// ----------------------------------------
	// track dc detect synchroniser
	// ----------------------------------------
	reg dc_meta_q;
	reg dc_sync_q;
	always @(posedge mclk) begin
		if (reset) begin
			dc_meta_q <= 1'b0;
			dc_sync_q <= 1'b0;
		end else begin
			dc_meta_q <= track_dc;
			dc_sync_q <= dc_meta_q;
		end
	end
	// ----------------------------------------
	// mode, limits and transponder latch
	// ----------------------------------------
	wire analog_d = dc_sync_q && (alt_power_q == `ASAC_ALT_ANALOG) &&
		basic_cfg_q[`ASAC_CFG_ANALOG];
	wire [8:0] start_sum = `ASAC_START_BASE_DV + {1'b0, start_v_q};
	wire overvolt = analog_q && (track_dv > `ASAC_OVERVOLT_DV);
	wire [8:0] dv_above = track_dv - start_sum;
	wire [6:0] analog_step = (track_dv <= start_sum) ? 7'h00 :
		(dv_above >= {2'b00, `ASAC_STEP_MAX}) ? `ASAC_STEP_MAX : dv_above[6:0];
	wire [6:0] step_d = shutdown_q ? 7'h00 : (analog_q ? analog_step : cmd_step);
	always @(posedge mclk) begin
		if (reset) begin
			analog_q <= 1'b0;
			start_dv_q <= `ASAC_START_BASE_DV;
			max_avg_dv_q <= 8'hff;
			load_comp_en_q <= 1'b1;
			auto_exhaust_q <= 1'b0;
			chuff_rate_q <= 8'h00;
			shutdown_q <= 1'b0;
			func_force_q <= 14'h0000;
			xpond_compat_q <= 1'b0;
		end else begin
			analog_q <= analog_d;
			start_dv_q <= start_sum;
			// the average is capped, the pwm peak still reaches track voltage
			max_avg_dv_q <= analog_q ? max_v_q : 8'hff;
			load_comp_en_q <= !analog_q;
			auto_exhaust_q <= analog_q;
			chuff_rate_q <= chuff_q;
			shutdown_q <= overvolt;
			// held as a level so downstream mapping sees a pressed key
			func_force_q <= analog_q ? {force_hi_q[5:0], force_lo_q} : 14'h0000;
			if (power_cycle) begin
				xpond_compat_q <= (xpond_q == `ASAC_XPOND_ON);
			end
		end
	end
	// ----------------------------------------
	// speed and direction
	// ----------------------------------------
	wire [7:0] en_sel = analog_q ? en_analog_q : en_digital_q;
	always @(posedge mclk) begin
		if (reset) begin
			speed_step_q <= 7'h00;
			dir_fwd_q <= 1'b1;
		end else begin
			speed_step_q <= step_d;
			if (!analog_q || speed_step_q == 7'h00) begin
				dir_fwd_q <= cmd_dir_fwd;
			end
		end
	end
	// ----------------------------------------
	// trigger qualifiers
	// ----------------------------------------
	// the start signal follows the direction being taken, not the one held
	wire dir_d = (!analog_q || speed_step_q == 7'h00) ? cmd_dir_fwd : dir_fwd_q;
	// triggers stay quiet while overvoltage holds the motor off
	wire sound_ok = !shutdown_q;
	// ----------------------------------------
	// stop and start whistles, steam release
	// ----------------------------------------
	wire stopping = (speed_step_q != 7'h00) && (step_d == 7'h00);
	wire starting = (speed_step_q == 7'h00) && (step_d != 7'h00);
	always @(posedge mclk) begin
		if (reset) begin
			toot_go_q <= 1'b0;
			toot_count_q <= 2'h0;
			toot_len_q <= 2'h0;
			steam_go_q <= 1'b0;
		end else begin
			toot_go_q <= sound_ok && en_sel[`ASAC_EN_WHISTLE] &&
				(stopping || starting);
			if (stopping) begin
				toot_count_q <= 2'h1;
				toot_len_q <= 2'h0;
			end else if (starting && dir_d) begin
				toot_count_q <= 2'h2;
				toot_len_q <= 2'h1;
			end else if (starting) begin
				toot_count_q <= 2'h3;
				toot_len_q <= 2'h0;
			end
			steam_go_q <= sound_ok && en_sel[`ASAC_EN_STEAM] &&
				stopping;
		end
	end
	// ----------------------------------------
	// sudden change detection over the sample interval
	// ----------------------------------------
	reg [27:0] samp_tmr_q;
	reg [6:0] samp_step_q;
	wire samp_tick = (samp_tmr_q == 28'h0000000);
	wire [7:0] rise = {1'b0, speed_step_q} - {1'b0, samp_step_q};
	wire [7:0] fall = {1'b0, samp_step_q} - {1'b0, speed_step_q};
	wire up = speed_step_q > samp_step_q;
	wire down = speed_step_q < samp_step_q;
	always @(posedge mclk) begin
		if (reset) begin
			samp_tmr_q <= SAMPLE_CYC - 28'h0000001;
			samp_step_q <= 7'h00;
			crossing_go_q <= 1'b0;
			squeal_go_q <= 1'b0;
		end else begin
			crossing_go_q <= 1'b0;
			squeal_go_q <= 1'b0;
			if (samp_tick) begin
				samp_tmr_q <= SAMPLE_CYC - 28'h0000001;
				samp_step_q <= speed_step_q;
				// a spike shorter than one interval can slip by; the cost of a cheap detector
				crossing_go_q <= sound_ok && en_sel[`ASAC_EN_XING] && up &&
					(rise >= xing_sens_q);
				squeal_go_q <= sound_ok && en_sel[`ASAC_EN_SQUEAL] && down &&
					(fall >= squeal_sens_q);
			end else begin
				samp_tmr_q <= samp_tmr_q - 28'h0000001;
			end
		end
	end
	// ----------------------------------------
	// automatic bell
	// ----------------------------------------
	wire [7:0] step8 = {1'b0, speed_step_q};
	wire bell_ok = sound_ok && en_sel[`ASAC_EN_BELL] &&
		(bell_off_sp_q > bell_on_sp_q);
	always @(posedge mclk) begin
		if (reset) begin
			bell_on_q <= 1'b0;
		end else if (!bell_ok) begin
			bell_on_q <= 1'b0;
		end else if (step8 > bell_off_sp_q || step8 < bell_on_sp_q) begin
			bell_on_q <= 1'b0;
		end else if (step8 == bell_on_sp_q) begin
			// inside the band but above the on point does not re-arm
			bell_on_q <= 1'b1;
		end
	end
	// ----------------------------------------
	// fault flasher on diagnostic, head and backup lights
	// ----------------------------------------
	// overvoltage is the only fault raised here, so the code is fixed
	wire lamp;
	asac_flash #(
		.FLASH_CYC(FLASH_CYC),
		.GAP_CYC(GAP_CYC)
	) u_flash (
		.mclk(mclk),
		.reset(reset),
		.active(shutdown_q),
		.code(`ASAC_ERR_OVERVOLT),
		.lamp_q(lamp)
	);
	always @(posedge mclk) begin
		if (reset) begin
			fault_lamp_q <= 1'b0;
			head_flash_q <= 1'b0;
			back_flash_q <= 1'b0;
		end else begin
			fault_lamp_q <= lamp;
			head_flash_q <= lamp;
			back_flash_q <= lamp;
		end
	end
endmodule // asac_ctrl
`default_nettype wire

// ### hw/asac_defines.vh
// register offsets, field positions, reset values and timing for the auto sound control
`ifndef ASAC_DEFINES_VH
`define ASAC_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ASAC_OFS_ALT_POWER 8'h0c
`define ASAC_OFS_FORCE_LO 8'h0d
`define ASAC_OFS_FORCE_HI 8'h0e
`define ASAC_OFS_BASIC_CFG 8'h1d
`define ASAC_OFS_XPOND 8'h3e
`define ASAC_OFS_START_V 8'h3f
`define ASAC_OFS_MAX_V 8'h40
`define ASAC_OFS_CHUFF 8'h74
`define ASAC_OFS_BELL_ON 8'hc1
`define ASAC_OFS_BELL_OFF 8'hc2
`define ASAC_OFS_XING_SENS 8'hc3
`define ASAC_OFS_SQUEAL_SENS 8'hc4
`define ASAC_OFS_EN_ANALOG 8'hc5
`define ASAC_OFS_EN_DIGITAL 8'hc6
`define ASAC_OFS_STATUS 8'hf0
// ----------------------------------------
// field positions
// ----------------------------------------
`define ASAC_EN_STEAM 4
`define ASAC_EN_WHISTLE 3
`define ASAC_EN_XING 2
`define ASAC_EN_BELL 1
`define ASAC_EN_SQUEAL 0
`define ASAC_CFG_ANALOG 2
// ----------------------------------------
// reset values
// ----------------------------------------
`define ASAC_RST_ALT_POWER 8'h00
`define ASAC_RST_FORCE_LO 8'h00
`define ASAC_RST_FORCE_HI 8'h00
`define ASAC_RST_BASIC_CFG 8'h00
`define ASAC_RST_XPOND 8'h00
`define ASAC_RST_START_V 8'h00
`define ASAC_RST_MAX_V 8'hff
`define ASAC_RST_CHUFF 8'h00
`define ASAC_RST_BELL_ON 8'h05
`define ASAC_RST_BELL_OFF 8'h0a
`define ASAC_RST_XING_SENS 8'h05
`define ASAC_RST_SQUEAL_SENS 8'h03
`define ASAC_RST_EN_ANALOG 8'h00
`define ASAC_RST_EN_DIGITAL 8'h00
// ----------------------------------------
// levels and timing
// ----------------------------------------
`define ASAC_ALT_ANALOG 8'h01
`define ASAC_XPOND_ON 8'h01
`define ASAC_START_BASE_DV 9'h04b
`define ASAC_OVERVOLT_DV 9'h0d2
`define ASAC_STEP_MAX 7'h7e
`define ASAC_ERR_OVERVOLT 5'h0a
`define ASAC_CLK_MHZ 100
`define ASAC_SAMPLE_MS 50
`define ASAC_FLASH_MS 250
`define ASAC_GAP_MS 1000
`define ASAC_SAMPLE_CYC (`ASAC_SAMPLE_MS * `ASAC_CLK_MHZ * 1000)
`define ASAC_FLASH_CYC (`ASAC_FLASH_MS * `ASAC_CLK_MHZ * 1000)
`define ASAC_GAP_CYC (`ASAC_GAP_MS * `ASAC_CLK_MHZ * 1000)
`endif

// ### hw/asac_flash.v
// error code flasher: blinks the code value, then a long gap, while active
`timescale 1ns/1ps
`default_nettype none
`include "asac_defines.vh"
module asac_flash #(
	parameter [27:0] FLASH_CYC = `ASAC_FLASH_CYC,
	parameter [27:0] GAP_CYC = `ASAC_GAP_CYC
) (
	// clock and reset
	input wire mclk,
	input wire reset,
	// control
	input wire active,
	input wire [4:0] code,
	// lamp
	output reg lamp_q
);
	// ----------------------------------------
	// blink sequencer
	// ----------------------------------------
	reg [27:0] tmr_q;
	reg [4:0] cnt_q;
	reg gap_q;
	always @(posedge mclk) begin
		if (reset || !active) begin
			tmr_q <= 28'h0000000;
			cnt_q <= 5'h00;
			gap_q <= 1'b0;
			lamp_q <= 1'b0;
		end else if (tmr_q != 28'h0000000) begin
			tmr_q <= tmr_q - 28'h0000001;
		end else if (gap_q) begin
			gap_q <= 1'b0;
			cnt_q <= 5'h00;
		end else if (!lamp_q) begin
			lamp_q <= 1'b1;
			tmr_q <= FLASH_CYC - 28'h0000001;
		end else begin
			// one flash per unit of the code value
			lamp_q <= 1'b0;
			if (cnt_q + 5'h01 >= code) begin
				gap_q <= 1'b1;
				tmr_q <= GAP_CYC - 28'h0000001;
			end else begin
				cnt_q <= cnt_q + 5'h01;
				tmr_q <= FLASH_CYC - 28'h0000001;
			end
		end
	end
endmodule // asac_flash
`default_nettype wire

// ### testbench/asac_ctrl_chk.sv
// assertion checker for the auto sound control ports
`timescale 1ns/1ps
`default_nettype none
module asac_ctrl_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// watched ports
	input wire logic [8:0] track_dv,
	input wire logic [6:0] speed_step_q,
	input wire logic [13:0] func_force_q,
	input wire logic [1:0] toot_count_q,
	input wire logic [1:0] toot_len_q,
	input wire logic dir_fwd_q,
	input wire logic load_comp_en_q,
	input wire logic auto_exhaust_q,
	input wire logic shutdown_q,
	input wire logic toot_go_q,
	input wire logic steam_go_q,
	input wire logic analog_q,
	input wire logic fault_lamp_q,
	input wire logic head_flash_q,
	input wire logic back_flash_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	sequence s_stop;
		speed_step_q == 7'h00 && $past(speed_step_q) != 7'h00;
	endsequence
	sequence s_over;
		$rose(shutdown_q);
	endsequence
	AST_TOOT_STOP: assert property (toot_go_q && speed_step_q == 7'h00 |->
		toot_count_q == 2'h1 && toot_len_q == 2'h0) else $error("bad stop toot");
	AST_TOOT_START: assert property (toot_go_q && speed_step_q != 7'h00 |->
		toot_count_q == (dir_fwd_q ? 2'h2 : 2'h3) && toot_len_q == {1'b0, dir_fwd_q})
		else $error("bad start toot");
	AST_STEAM_STOP: assert property (steam_go_q |-> s_stop) else $error("steam off stop");
	AST_FORCE_OFF: assert property (!analog_q |=> func_force_q == 14'h0000)
		else $error("forced input outside analog");
	AST_MODE_COMP: assert property (1'b1 |=> load_comp_en_q == !$past(analog_q) &&
		auto_exhaust_q == $past(analog_q)) else $error("mode outputs wrong");
	AST_OVERVOLT: assert property (analog_q && track_dv > 9'h0d2 |=> shutdown_q)
		else $error("no shutdown");
	AST_LAMPS_SAME: assert property (fault_lamp_q == head_flash_q &&
		fault_lamp_q == back_flash_q) else $error("lamps differ");
	AST_FLASH_START: assert property (s_over |-> ##[1:4] fault_lamp_q)
		else $error("no flash");
	AST_DIR_STOPPED: assert property (analog_q && $past(analog_q) &&
		dir_fwd_q != $past(dir_fwd_q) |-> $past(speed_step_q) == 7'h00) else $error("dir moving");
	AST_SHUT_QUIET: assert property (shutdown_q |=> !toot_go_q && !steam_go_q)
		else $error("sound during shutdown");
endmodule // asac_ctrl_chk
bind asac_ctrl asac_ctrl_chk chk_u (.mclk, .reset, .track_dv, .speed_step_q, .func_force_q,
	.toot_count_q, .toot_len_q, .dir_fwd_q, .load_comp_en_q, .auto_exhaust_q, .shutdown_q,
	.toot_go_q, .steam_go_q, .analog_q, .fault_lamp_q, .head_flash_q, .back_flash_q);
`default_nettype wire

// ### testbench/asac_pack.sv
// far side model: command station or dc power pack
`timescale 1ns/1ps
`default_nettype none
module asac_pack (
	// clock
	input wire logic mclk,
	// settings from the bench
	input wire logic dc_mode,
	input wire logic [8:0] volts_dv,
	input wire logic [6:0] step,
	input wire logic fwd,
	// track and command lines
	output logic track_dc = 1'b0,
	output logic [8:0] track_dv = 9'h000,
	output logic [6:0] cmd_step = 7'h00,
	output logic cmd_dir_fwd = 1'b1
);
	logic [3:0] dc_age = 4'h0;
	// a pack sends no commands: the step lines wander once the mode has settled,
	// delayed so the decoder is not fed junk while it still runs digital
	always @(posedge mclk) begin
		dc_age <= {dc_age[2:0], dc_mode};
		track_dc <= dc_mode;
		track_dv <= volts_dv;
		cmd_step <= dc_age[3] ? ~cmd_step : step;
		cmd_dir_fwd <= fwd;
	end
endmodule // asac_pack
`default_nettype wire

// ### testbench/asac_ctrl_bench.sv
// self-checking bench for the auto sound control
`timescale 1ns/1ps
`default_nettype none
module asac_ctrl_bench;
	localparam int SMP = 20;
	logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, power_cycle = 1'b0;
	logic dc_mode = 1'b0, fwd = 1'b1, lamp_d = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [8:0] volts_dv = 9'h000;
	logic [6:0] step = 7'h00;
	int n_mismatch = 0, n_compared = 0, cyc = 0, n_t = 0, n_x = 0, n_s = 0, n_q = 0, n_l = 0;
	int b_t = 0, b_x = 0, b_s = 0, b_q = 0, b_l = 0;
	logic [7:0] ofs [11] = '{8'h0d, 8'h0e, 8'h3e, 8'h3f, 8'h40, 8'hc1, 8'hc2, 8'hc3, 8'hc4,
		8'hc5, 8'hc6};
	logic [7:0] dflt [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h05, 8'h0a, 8'h05, 8'h03,
		8'h00, 8'h00};
	wire track_dc, cmd_dir_fwd, dir_fwd_q, load_comp_en_q, auto_exhaust_q, shutdown_q;
	wire toot_go_q, crossing_go_q, steam_go_q, squeal_go_q, bell_on_q, analog_q;
	wire xpond_compat_q, fault_lamp_q, head_flash_q, back_flash_q;
	wire [1:0] toot_count_q, toot_len_q;
	wire [6:0] cmd_step, speed_step_q;
	wire [7:0] reg_rdata, max_avg_dv_q, chuff_rate_q;
	wire [8:0] track_dv, start_dv_q;
	wire [13:0] func_force_q;
	asac_pack pack_u (.mclk, .dc_mode, .volts_dv, .step, .fwd, .track_dc, .track_dv, .cmd_step,
		.cmd_dir_fwd);
	asac_ctrl #(.SAMPLE_CYC(28'h14), .FLASH_CYC(28'h4), .GAP_CYC(28'h10)) dut_u (.mclk, .reset,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .track_dc, .power_cycle, .track_dv,
		.cmd_step, .cmd_dir_fwd, .speed_step_q, .dir_fwd_q, .start_dv_q, .max_avg_dv_q,
		.load_comp_en_q, .auto_exhaust_q, .chuff_rate_q, .shutdown_q, .func_force_q, .toot_go_q,
		.toot_count_q, .toot_len_q, .crossing_go_q, .steam_go_q, .squeal_go_q, .bell_on_q,
		.analog_q, .xpond_compat_q, .fault_lamp_q, .head_flash_q, .back_flash_q);
	always #5 mclk = ~mclk;
	// pulse counters; steps compare differences against a saved base, so no clearing race
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		n_t <= n_t + toot_go_q;
		n_x <= n_x + crossing_go_q;
		n_s <= n_s + steam_go_q;
		n_q <= n_q + squeal_go_q;
		lamp_d <= fault_lamp_q;
		// a flash only counts when all three lamps light together
		n_l <= n_l + (fault_lamp_q & head_flash_q & back_flash_q & ~lamp_d);
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		idle(1);
		reg_wr <= 1'b0;
		idle(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		idle(1);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		idle(1);
	endtask
	task automatic pc();
		power_cycle <= 1'b1;
		idle(1);
		power_cycle <= 1'b0;
		idle(2);
	endtask
	task automatic go(input logic [6:0] s);
		step <= s;
		idle(2 * SMP + 4);
	endtask
	task automatic counts(input int t, input int x, input int s, input int q);
		chk(16'(n_t - b_t), 16'(t));
		chk(16'(n_x - b_x), 16'(x));
		chk(16'(n_s - b_s), 16'(s));
		chk(16'(n_q - b_q), 16'(q));
		b_t = n_t;
		b_x = n_x;
		b_s = n_s;
		b_q = n_q;
	endtask
	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		idle(5);
		reset <= 1'b0;
		idle(1);
		for (int i = 0; i < 11; i++) begin
			rd(ofs[i], dflt[i]);
			wr(ofs[i], ofs[i] ^ 8'h5a);
			rd(ofs[i], ofs[i] ^ 8'h5a);
		end
		wr(8'h50, 8'hff);
		rd(8'h50, 8'h00);
		wr(8'h3e, 8'h01);
		chk(xpond_compat_q, 16'h0);
		pc();
		chk(xpond_compat_q, 16'h1);
		wr(8'h3e, 8'h00);
		chk(xpond_compat_q, 16'h1);
		pc();
		chk(xpond_compat_q, 16'h0);
		$display("registers done");
		wr(8'hc6, 8'h1f);
		wr(8'hc1, 8'h05);
		wr(8'hc2, 8'h0a);
		wr(8'hc3, 8'h05);
		wr(8'hc4, 8'h03);
		go(7'h0a);
		counts(1, 1, 0, 0);
		chk({toot_count_q, toot_len_q}, 16'h9);
		chk(bell_on_q, 16'h0);
		go(7'h00);
		counts(1, 0, 1, 1);
		chk({toot_count_q, toot_len_q}, 16'h4);
		fwd <= 1'b0;
		go(7'h03);
		counts(1, 0, 0, 0);
		chk({toot_count_q, toot_len_q}, 16'hc);
		go(7'h05);
		chk(bell_on_q, 16'h1);
		go(7'h0a);
		chk(bell_on_q, 16'h1);
		counts(0, 1, 0, 0);
		go(7'h0b);
		chk(bell_on_q, 16'h0);
		go(7'h08);
		chk(bell_on_q, 16'h0);
		go(7'h05);
		chk(bell_on_q, 16'h1);
		counts(0, 0, 0, 2);
		go(7'h04);
		chk(bell_on_q, 16'h0);
		wr(8'hc2, 8'h05);
		go(7'h05);
		chk(bell_on_q, 16'h0);
		wr(8'hc6, 8'h10);
		go(7'h09);
		go(7'h00);
		counts(0, 0, 1, 0);
		$display("digital done");
		wr(8'hc6, 8'h00);
		wr(8'hc5, 8'h0b);
		wr(8'h0c, 8'h01);
		wr(8'h1d, 8'h04);
		wr(8'h3f, 8'h0a);
		wr(8'h40, 8'hb4);
		wr(8'h74, 8'h33);
		wr(8'h0d, 8'ha5);
		wr(8'h0e, 8'h2a);
		fwd <= 1'b1;
		volts_dv <= 9'h055;
		dc_mode <= 1'b1;
		idle(10);
		chk(analog_q, 16'h1);
		chk(func_force_q, 16'h2aa5);
		chk(start_dv_q, 16'h55);
		chk(max_avg_dv_q, 16'hb4);
		chk({load_comp_en_q, auto_exhaust_q, chuff_rate_q}, 16'h133);
		volts_dv <= 9'h069;
		idle(2 * SMP + 4);
		chk(speed_step_q, 16'h14);
		rd(8'hf0, 8'h07);
		counts(1, 0, 0, 0);
		fwd <= 1'b0;
		idle(10);
		chk(dir_fwd_q, 16'h1);
		volts_dv <= 9'h055;
		idle(2 * SMP + 4);
		counts(1, 0, 0, 1);
		chk(dir_fwd_q, 16'h0);
		volts_dv <= 9'h0d2;
		idle(10);
		chk(shutdown_q, 16'h0);
		b_l = n_l;
		volts_dv <= 9'h0d3;
		idle(90);
		chk(shutdown_q, 16'h1);
		chk(speed_step_q, 16'h0);
		chk(16'(n_l - b_l), 16'ha);
		rd(8'hf0, 8'h09);
		volts_dv <= 9'h096;
		idle(10);
		chk(shutdown_q, 16'h0);
		wr(8'h0c, 8'h00);
		idle(4);
		chk(analog_q, 16'h0);
		chk(func_force_q, 16'h0);
		$display("analog done");
		summarize();
	end
endmodule // asac_ctrl_bench
`default_nettype wire
